/* File: hprs_pkg.sv */
`default_nettype none
package hprs_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_HOLDOVER_CONTROL = 8'h19;
  localparam logic [7:0] IDX_FINE_PHASE_OFFSET = 8'h1a;
  localparam logic [7:0] IDX_PRIMARY_STATUS = 8'h20;
  localparam logic [7:0] IDX_SECONDARY_STATUS = 8'h28;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  localparam logic [7:0] IDX_CORE_STATE = 8'h32;
  localparam logic [7:0] IDX_FILTER_SELECT = 8'h33;
  localparam int ADDR_W = 10;

  // Field positions
  localparam int BIT_RELEASE = 2;
  localparam int BIT_INHIBIT = 1;
  localparam int BIT_RATE_HI = 4;
  localparam int BIT_RATE_LO = 3;
  localparam int BIT_MON_HOLD = 1;
  localparam int BIT_CAP_LIM = 0;
  // Reference rate code of the 8 kHz input
  localparam logic [1:0] RATE_8K = 2'h1;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [3:0] RST_MASK = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: 125 MHz clock
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TRIM_STEP_PS = 477;
  // Stratum 3 slew: 885 ns/s; one 477 ps step per 539 us
  localparam longint SLEW_S3_NS_PER_S = 885;
  localparam longint SLEW_S3_CYCLES = (longint'(TRIM_STEP_PS) * 125000000) / (SLEW_S3_NS_PER_S * 1000);
  // Other filters: 41 ns per 1.326 ms
  localparam longint SLEW_OTHER_NS = 41;
  localparam longint SLEW_OTHER_WINDOW_NS = 1326000;
  localparam longint SLEW_OTHER_CYCLES =
    (longint'(TRIM_STEP_PS) * SLEW_OTHER_WINDOW_NS) / (SLEW_OTHER_NS * 1000 * CLK_PERIOD_PS / 1000);
  localparam int QUIET_REF_CYCLES = 64;

  typedef enum logic [2:0] {
    CORE_NORMAL = 3'b001,
    CORE_AUTO_HOLD = 3'b010,
    CORE_WAIT_QUIET = 3'b100
  } hprs_core_t;

  typedef struct packed {
    logic [1:0] rate_code;
    logic holdover;
    logic capture_limit;
    logic phase_hit;
  } hprs_mon_t;
endpackage
`default_nettype wire

/* File: hprs_slew.sv */
`default_nettype none
module hprs_slew
  import hprs_pkg::*;
#(
  parameter longint S3_CYCLES = SLEW_S3_CYCLES,
  parameter longint OTHER_CYCLES = SLEW_OTHER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Target and mode
  input wire logic [7:0] target,
  input wire logic stratum3,
  // Applied offset in steps
  output logic [7:0] applied
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [7:0] applied;
  } hprs_slew_st_t;

  hprs_slew_st_t q, d;

  always_comb begin
    logic [31:0] limit;
    limit = stratum3 ? 32'(S3_CYCLES) : 32'(OTHER_CYCLES);
    d = q;
    // One step per slew interval, signed comparison
    if (q.applied == target) begin
      d.cnt = '0;
    end else if (q.cnt >= limit - 32'h1) begin
      d.cnt = '0;
      if ($signed(target) > $signed(q.applied)) begin
        d.applied = q.applied + 8'h01;
      end else begin
        d.applied = q.applied - 8'h01;
      end
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign applied = q.applied;
endmodule
`default_nettype wire

/* File: hprs_regs.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
// Overview of operation
// - Release trigger rising edge returns core to normal
// - Trigger ignored while return inhibit clear
// - Inhibit keeps core in auto holdover
// - Only active monitor lock governs return
// - Eight-bit phase trim shifts all outputs
// - Trim is two's complement, positive advances
// - Applied phase changes are slew limited
// - Primary status reports primary rate code
// - Secondary status reports secondary rate code
// - Primary holdover flag follows primary monitor
// - Secondary holdover flag follows secondary monitor
// - Primary capture limit flag beyond 104 ppm
// - Secondary capture limit flag beyond 104 ppm
// - Auto return after 64 quiet reference cycles
// - Trigger during monitor holdover is lost
// - Half-cycle phase hit counts as failure, except on 8 kHz references
module hprs_regs
  import hprs_pkg::*;
#(
  parameter longint S3_CYCLES = SLEW_S3_CYCLES,
  parameter longint OTHER_CYCLES = SLEW_OTHER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Monitors; one per reference, ref_tick is one reference clock cycle
  input wire hprs_mon_t primary_mon,
  input wire hprs_mon_t secondary_mon,
  input wire logic secondary_active,
  input wire logic ref_tick,
  // Core PLL control
  output logic core_holdover,
  output logic [7:0] output_phase_trim,
  // Interrupt
  output logic irq
);
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction

  function automatic logic [7:0] status_byte(input hprs_mon_t m);
    status_byte = {3'h0, m.rate_code, 1'b0, m.holdover, m.capture_limit};
  endfunction

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_idx;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic release_trig;
    logic auto_inhibit;
    logic [7:0] trim;
    logic stratum3;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
    logic prev_hold;
    logic prev_lim;
    hprs_core_t core;
    logic core_hold;
    logic [6:0] quiet;
  } hprs_st_t;

  hprs_st_t q, d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] applied;
  hprs_mon_t act;

  // Release synchronised; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Limiter follows the written value; reads return it unslewed
  hprs_slew #(
    .S3_CYCLES(S3_CYCLES),
    .OTHER_CYCLES(OTHER_CYCLES)
  ) i_hprs_slew (
    .clk(clk),
    .rst_n(rst_n),
    .target(q.trim),
    .stratum3(q.stratum3),
    .applied(applied)
  );

  // Only the monitor feeding the core counts
  assign act = secondary_active ? secondary_mon : primary_mon;

  always_comb begin
    logic [3:0] ev;
    logic wr_fire;
    logic [7:0] widx;
    logic [7:0] wb;
    logic rel_rise;
    logic hit;
    d = q;
    ev = 4'h0;
    wr_fire = 1'b0;
    widx = q.aw_idx;
    wb = q.wdata[7:0];
    rel_rise = 1'b0;
    // 8 kHz references have no half-cycle hit criterion
    hit = act.phase_hit && (act.rate_code != RATE_8K);

    // Write channel: address and data in either order
    if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got = 1'b1;
      d.aw_idx = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      wr_fire = 1'b1;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (widx)
        IDX_HOLDOVER_CONTROL: begin
          if (q.wstrb[0]) begin
            // Reserved bits are not stored
            d.release_trig = wb[BIT_RELEASE];
            d.auto_inhibit = wb[BIT_INHIBIT];
            rel_rise = wb[BIT_RELEASE] && !q.release_trig;
          end
        end
        IDX_FINE_PHASE_OFFSET: begin
          if (q.wstrb[0]) begin
            d.trim = wb;
          end
        end
        IDX_IRQ_MASK: begin
          if (q.wstrb[0]) begin
            d.irq_mask = wb[3:0];
          end
        end
        IDX_FILTER_SELECT: begin
          if (q.wstrb[0]) begin
            d.stratum3 = wb[0];
          end
        end
        IDX_PRIMARY_STATUS, IDX_SECONDARY_STATUS, IDX_IRQ_STATUS, IDX_CORE_STATE: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Read channel
    // One read at a time; arready pulses with rvalid
    d.arready = 1'b0;
    if (s_axi_arvalid && !q.arready && !q.rvalid) begin
      d.arready = 1'b1;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0;
      case (reg_index(s_axi_araddr))
        IDX_HOLDOVER_CONTROL: d.rdata[7:0] = {5'h0, q.release_trig, q.auto_inhibit, 1'b0};
        IDX_FINE_PHASE_OFFSET: d.rdata[7:0] = q.trim;
        IDX_PRIMARY_STATUS: d.rdata[7:0] = status_byte(primary_mon);
        IDX_SECONDARY_STATUS: d.rdata[7:0] = status_byte(secondary_mon);
        IDX_IRQ_STATUS: d.rdata[3:0] = q.irq_status;
        IDX_IRQ_MASK: d.rdata[3:0] = q.irq_mask;
        IDX_CORE_STATE: d.rdata[7:0] = {5'h0, q.core};
        IDX_FILTER_SELECT: d.rdata[0] = q.stratum3;
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Core PLL holdover state
    d.prev_hold = act.holdover;
    d.prev_lim = act.capture_limit;
    case (q.core)
      CORE_NORMAL: begin
        // Phase hits beyond half a cycle are reported as holdover entry
        if (act.holdover || hit) begin
          d.core = CORE_AUTO_HOLD;
          ev[0] = 1'b1;
        end
      end
      CORE_AUTO_HOLD: begin
        if (!act.holdover) begin
          if (q.auto_inhibit) begin
            if (rel_rise) begin
              d.core = CORE_NORMAL;
              ev[1] = 1'b1;
            end
          end else begin
            d.core = CORE_WAIT_QUIET;
            d.quiet = 7'h0;
          end
        end
        // A trigger while still in holdover is simply dropped
      end
      CORE_WAIT_QUIET: begin
        if (act.holdover) begin
          d.core = CORE_AUTO_HOLD;
        end else if (hit) begin
          d.quiet = 7'h0;
        end else if (q.auto_inhibit) begin
          d.core = CORE_AUTO_HOLD;
        end else if (q.quiet >= 7'(QUIET_REF_CYCLES)) begin
          d.core = CORE_NORMAL;
          ev[1] = 1'b1;
        end else if (ref_tick) begin
          d.quiet = q.quiet + 7'h1;
        end
      end
      default: d.core = CORE_AUTO_HOLD;
    endcase
    if (q.core == CORE_AUTO_HOLD && act.holdover && rel_rise) begin
      d.core = CORE_AUTO_HOLD;
    end

    // Sticky events: core holdover entry, return, monitor holdover, capture limit
    ev[2] = act.holdover && !q.prev_hold;
    ev[3] = act.capture_limit && !q.prev_lim;
    if (wr_fire && widx == IDX_IRQ_STATUS && q.wstrb[0]) begin
      d.irq_status = q.irq_status & ~wb[3:0];
    end
    // Set wins over a same-cycle clear
    d.irq_status = d.irq_status | ev;
    // Registered so irq and the mode pin come straight from flops
    d.irq = |(d.irq_status & d.irq_mask);
    d.core_hold = (d.core != CORE_NORMAL);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.aw_got <= 1'b0;
      q.aw_idx <= 8'h00;
      q.w_got <= 1'b0;
      q.wdata <= 32'h0;
      q.wstrb <= 4'h0;
      q.bvalid <= 1'b0;
      q.bresp <= RESP_OKAY;
      q.arready <= 1'b0;
      q.rvalid <= 1'b0;
      q.rdata <= 32'h0;
      q.rresp <= RESP_OKAY;
      q.release_trig <= RST_CONTROL[BIT_RELEASE];
      q.auto_inhibit <= RST_CONTROL[BIT_INHIBIT];
      q.trim <= RST_TRIM;
      q.stratum3 <= 1'b0;
      q.irq_status <= 4'h0;
      q.irq_mask <= RST_MASK;
      q.irq <= 1'b0;
      q.prev_hold <= 1'b0;
      q.prev_lim <= 1'b0;
      q.core <= CORE_AUTO_HOLD;
      q.core_hold <= 1'b1;
      q.quiet <= 7'h0;
    end else begin
      q.aw_got <= d.aw_got;
      q.aw_idx <= d.aw_idx;
      q.w_got <= d.w_got;
      q.wdata <= d.wdata;
      q.wstrb <= d.wstrb;
      q.bvalid <= d.bvalid;
      q.bresp <= d.bresp;
      q.arready <= d.arready;
      q.rvalid <= d.rvalid;
      q.rdata <= d.rdata;
      q.rresp <= d.rresp;
      q.release_trig <= d.release_trig;
      q.auto_inhibit <= d.auto_inhibit;
      q.trim <= d.trim;
      q.stratum3 <= d.stratum3;
      q.irq_status <= d.irq_status;
      q.irq_mask <= d.irq_mask;
      q.irq <= d.irq;
      q.prev_hold <= d.prev_hold;
      q.prev_lim <= d.prev_lim;
      q.core <= d.core;
      q.core_hold <= d.core_hold;
      q.quiet <= d.quiet;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = q.aw_got;
  assign s_axi_wready = q.w_got;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign core_holdover = q.core_hold;
  assign output_phase_trim = applied;
  assign irq = q.irq;
endmodule
`default_nettype wire

/* File: hprs_regs_properties.sv */
`default_nettype none
module hprs_regs_properties
  import hprs_pkg::*;
#(
  parameter longint S3_CYCLES = SLEW_S3_CYCLES,
  parameter longint OTHER_CYCLES = SLEW_OTHER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus answers
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Monitors and core
  input wire hprs_mon_t primary_mon,
  input wire hprs_mon_t secondary_mon,
  input wire logic secondary_active,
  input wire logic core_holdover,
  input wire logic [7:0] output_phase_trim
);
  hprs_mon_t act;
  logic hit_counts;
  assign act = secondary_active ? secondary_mon : primary_mon;
  assign hit_counts = act.phase_hit && (act.rate_code != RATE_8K);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_read_ans;
    s_axi_arready && s_axi_rvalid;
  endsequence
  // Short step spacing in sim; real intervals are far longer
  sequence s_trim_steady;
    $stable(output_phase_trim) [*2];
  endsequence
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_read_ans)
    else $error("read not answered");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  a_trim_step: assert property (8'(output_phase_trim - $past(output_phase_trim)) inside {8'h00, 8'h01, 8'hff})
    else $error("trim jumped");
  a_trim_spacing: assert property ($changed(output_phase_trim) |=> s_trim_steady)
    else $error("trim steps too close");
  a_hit_forces: assert property (!core_holdover && hit_counts |-> ##[1:8] core_holdover)
    else $error("phase hit ignored");
  a_hold_follows: assert property (!core_holdover && act.holdover |-> ##[1:3] core_holdover)
    else $error("monitor holdover ignored");
  a_hold_keeps: assert property (core_holdover && act.holdover |=> core_holdover)
    else $error("left holdover while monitor holds");
endmodule
bind hprs_regs hprs_regs_properties #(.S3_CYCLES(S3_CYCLES), .OTHER_CYCLES(OTHER_CYCLES)) i_hprs_regs_properties (
  .clk(clk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .primary_mon(primary_mon),
  .secondary_mon(secondary_mon), .secondary_active(secondary_active),
  .core_holdover(core_holdover), .output_phase_trim(output_phase_trim)
);
`default_nettype wire

/* File: hprs_regs_test.sv */
`default_nettype none
module hprs_regs_test
  import hprs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ref_tick = 1'b0, sec_act = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  hprs_mon_t pmon = '0, smon = '0;
  logic awready, wready, bvalid, arready, rvalid, core_hold, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] trim;
  int fails = 0, n_checks = 0;

  always #4 clk = ~clk;
  // Reference cycle of four clocks keeps the quiet count short
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    ref_tick <= (tcnt == 2'h3);
  end

  hprs_regs #(.S3_CYCLES(4), .OTHER_CYCLES(6)) i_hprs_regs (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primary_mon(pmon),
    .secondary_mon(smon), .secondary_active(sec_act), .ref_tick(ref_tick), .core_holdover(core_hold),
    .output_phase_trim(trim), .irq(irq)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  // Ready sampled mid-cycle, where registered outputs are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int t;
    t = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && t < 50) begin
      @(negedge clk);
      ta = awready === 1'b1;
      tw = wready === 1'b1;
      tb = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      t++;
    end
    chkb(tb, 1'b1);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] r;
    logic [31:0] v;
    int t;
    t = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && t < 50) begin
      @(negedge clk);
      ta = arready === 1'b1;
      tr = rvalid === 1'b1;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      t++;
    end
    chkb(tr, 1'b1);
    chk({30'h0, r}, {30'h0, er});
    if (er == RESP_OKAY) chk(v, {24'h0, e});
  endtask

  // Waits for core holdover flag (tr=0) or applied trim (tr=1) to reach e
  task automatic settle(input bit tr, input logic [7:0] e, input int n);
    logic [7:0] v;
    int t;
    t = 0;
    do begin
      @(negedge clk);
      v = tr ? trim : {7'h0, core_hold};
      t++;
    end while (v !== e && t < n);
    chk({24'h0, v}, {24'h0, e});
    @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(IDX_HOLDOVER_CONTROL, RST_CONTROL, RESP_OKAY);
    rd(IDX_FINE_PHASE_OFFSET, RST_TRIM, RESP_OKAY);
    rd(IDX_IRQ_MASK, {4'h0, RST_MASK}, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      pmon <= {i[1:0], i[0], i[1], 1'b0};
      smon <= {~i[1:0], i[1], i[0], 1'b0};
      rd(IDX_PRIMARY_STATUS, {3'h0, i[1:0], 1'b0, i[0], i[1]}, RESP_OKAY);
      rd(IDX_SECONDARY_STATUS, {3'h0, ~i[1:0], 1'b0, i[1], i[0]}, RESP_OKAY);
    end
    pmon <= '0;
    smon <= '0;
    wr(IDX_PRIMARY_STATUS, 8'hff, RESP_OKAY);
    rd(IDX_PRIMARY_STATUS, 8'h00, RESP_OKAY);
    wr(IDX_HOLDOVER_CONTROL, 8'hff, RESP_OKAY);
    rd(IDX_HOLDOVER_CONTROL, 8'h06, RESP_OKAY);
    wr(IDX_HOLDOVER_CONTROL, 8'h00, RESP_OKAY);
    wr(8'h3f, 8'h5a, RESP_SLVERR);
    rd(8'h3f, 8'h00, RESP_SLVERR);
    pmon.holdover <= 1'b1;
    settle(0, 8'h01, 10);
    pmon.holdover <= 1'b0;
    repeat (100) @(posedge clk);
    pmon.phase_hit <= 1'b1;
    repeat (4) @(posedge clk);
    pmon.phase_hit <= 1'b0;
    repeat (200) @(posedge clk);
    settle(0, 8'h01, 1);
    settle(0, 8'h00, 120);
    pmon.phase_hit <= 1'b1;
    settle(0, 8'h01, 8);
    pmon.phase_hit <= 1'b0;
    settle(0, 8'h00, 400);
    pmon <= {RATE_8K, 1'b0, 1'b0, 1'b1};
    repeat (8) @(posedge clk);
    settle(0, 8'h00, 1);
    sec_act <= 1'b1;
    pmon <= {RATE_8K, 1'b1, 1'b0, 1'b0};
    repeat (20) @(posedge clk);
    settle(0, 8'h00, 1);
    smon.holdover <= 1'b1;
    settle(0, 8'h01, 8);
    smon.holdover <= 1'b0;
    pmon.holdover <= 1'b0;
    wr(IDX_HOLDOVER_CONTROL, 8'h04, RESP_OKAY);
    wr(IDX_HOLDOVER_CONTROL, 8'h00, RESP_OKAY);
    settle(0, 8'h01, 1);
    wr(IDX_HOLDOVER_CONTROL, 8'h02, RESP_OKAY);
    repeat (400) @(posedge clk);
    settle(0, 8'h01, 1);
    smon.holdover <= 1'b1;
    wr(IDX_HOLDOVER_CONTROL, 8'h06, RESP_OKAY);
    wr(IDX_HOLDOVER_CONTROL, 8'h02, RESP_OKAY);
    settle(0, 8'h01, 1);
    smon.holdover <= 1'b0;
    wr(IDX_HOLDOVER_CONTROL, 8'h06, RESP_OKAY);
    settle(0, 8'h00, 10);
    wr(IDX_HOLDOVER_CONTROL, 8'h02, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 8'h0f, RESP_OKAY);
    @(negedge clk);
    chkb(irq, 1'b0);
    wr(IDX_IRQ_MASK, 8'h0f, RESP_OKAY);
    repeat (2) @(negedge clk);
    chkb(irq, 1'b1);
    wr(IDX_IRQ_STATUS, 8'h0f, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
    @(negedge clk);
    chkb(irq, 1'b0);
    wr(IDX_FILTER_SELECT, 8'h00, RESP_OKAY);
    wr(IDX_FINE_PHASE_OFFSET, 8'h80, RESP_OKAY);
    settle(1, 8'hff, 20);
    repeat (4) @(negedge clk);
    chk({24'h0, trim}, 32'h000000ff);
    settle(1, 8'h80, 900);
    rd(IDX_FINE_PHASE_OFFSET, 8'h80, RESP_OKAY);
    wr(IDX_FILTER_SELECT, 8'h01, RESP_OKAY);
    wr(IDX_FINE_PHASE_OFFSET, 8'h02, RESP_OKAY);
    settle(1, 8'h81, 20);
    repeat (4) @(negedge clk);
    chk({24'h0, trim}, 32'h00000082);
    settle(1, 8'h02, 700);
    end_of_test();
  end

  // Whole sequence needs about 2500 cycles
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
